// file: smd_pkg.sv
// shared constants and types of the signed multiply-accumulate unit
package smd_pkg;
    localparam int          DATA_W         = 32;
    localparam int          HALF_W         = 16;
    localparam int          LONG_W         = 64;
    // register byte offsets
    localparam logic [11:0] OFS_FIRST_OP   = 12'h000;
    localparam logic [11:0] OFS_SECOND_OP  = 12'h004;
    localparam logic [11:0] OFS_ADDEND     = 12'h008;
    localparam logic [11:0] OFS_LOW_DEST   = 12'h00c;
    localparam logic [11:0] OFS_HIGH_DEST  = 12'h010;
    localparam logic [11:0] OFS_DEST       = 12'h014;
    localparam logic [11:0] OFS_CTRL       = 12'h018;
    localparam logic [11:0] OFS_STATUS     = 12'h01c;
    localparam logic [11:0] OFS_COND_FLAGS = 12'h020;
    localparam logic [11:0] OFS_IRQ_STAT   = 12'h024;
    localparam logic [11:0] OFS_IRQ_EN     = 12'h028;
    localparam logic [11:0] OFS_IRQ_CLR    = 12'h02c;
    // control field positions
    localparam int          CTRL_OP_LSB    = 0;
    localparam int          CTRL_OP_W      = 3;
    localparam int          CTRL_SWAP      = 3;
    localparam int          CTRL_ROUND     = 4;
    localparam int          CTRL_FIRST_TOP = 5;
    localparam int          CTRL_SECOND_TOP = 6;
    localparam int          CTRL_START     = 8;
    localparam int          CTRL_KEEP_W    = 7;
    // status and interrupt bit positions
    localparam int          ST_BUSY        = 0;
    localparam int          ST_SAT         = 1;
    localparam int          IRQ_DONE       = 0;
    localparam int          IRQ_SAT        = 1;
    localparam int          IRQ_W          = 2;
    localparam int          FLAGS_W        = 4;
    // reset values and constants
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    localparam logic [63:0] ROUND_CONST    = 64'h0000_0000_8000_0000;

    typedef enum logic [2:0] {
        OP_WORD_LONG_MAC,
        OP_HALF_LONG_MAC,
        OP_DUAL_HALF_LONG_MAC,
        OP_DUAL_HALF_MUL_SUB_ACC,
        OP_DUAL_HALF_MUL_SUB_LONG,
        OP_HIGH_WORD_MUL_ADD,
        OP_HIGH_WORD_MUL_SUBTRACT
    } smd_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MUL,
        ST_ACC
    } smd_state_t;
endpackage : smd_pkg

// file: smd_word_mul.sv
// registered signed 32x32 multiplier giving a 64-bit product
`timescale 1ns/1ps
module smd_word_mul (
    input  wire logic                       CLK_I,
    input  wire logic                       RESET_N_I,
    input  wire logic                       en_i,
    input  wire logic [smd_pkg::DATA_W-1:0] a_i,
    input  wire logic [smd_pkg::DATA_W-1:0] b_i,
    output logic      [smd_pkg::LONG_W-1:0] prod_o
);
    import smd_pkg::*;

    logic [LONG_W-1:0] prod_reg;
    logic [LONG_W-1:0] prod_next;

    // sign extension to full width keeps the low 64 product bits exact
    always_comb begin
        prod_next = prod_reg;
        if (en_i) begin
            prod_next = {{DATA_W{a_i[DATA_W-1]}}, a_i} * {{DATA_W{b_i[DATA_W-1]}}, b_i};
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            prod_reg <= '0;
        end else begin
            prod_reg <= prod_next;
        end
    end

    assign prod_o = prod_reg;
endmodule : smd_word_mul

// file: smd_half_mul.sv
// two registered signed 16x16 multiplier lanes
`timescale 1ns/1ps
module smd_half_mul (
    input  wire logic                         CLK_I,
    input  wire logic                         RESET_N_I,
    input  wire logic                         en_i,
    input  wire logic [2*smd_pkg::HALF_W-1:0] a_i,
    input  wire logic [2*smd_pkg::HALF_W-1:0] b_i,
    output logic      [2*smd_pkg::DATA_W-1:0] prod_o
);
    import smd_pkg::*;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            logic [HALF_W-1:0] a;
            logic [HALF_W-1:0] b;
            logic [DATA_W-1:0] prod_reg;
            logic [DATA_W-1:0] prod_next;

            assign a = a_i[g*HALF_W +: HALF_W];
            assign b = b_i[g*HALF_W +: HALF_W];

            always_comb begin
                prod_next = prod_reg;
                if (en_i) begin
                    prod_next = {{HALF_W{a[HALF_W-1]}}, a} * {{HALF_W{b[HALF_W-1]}}, b};
                end
            end

            always_ff @(posedge CLK_I or negedge RESET_N_I) begin
                if (!RESET_N_I) begin
                    prod_reg <= '0;
                end else begin
                    prod_reg <= prod_next;
                end
            end

            assign prod_o[g*DATA_W +: DATA_W] = prod_reg;
        end
    endgenerate
endmodule : smd_half_mul

// file: smd_mac_top.sv
// signed multiply-accumulate unit with apb register access
// Behaviour
// - word long mac: signed 64-bit product plus destination pair, written back
// - pair low register holds bits 31..0, high register bits 63..32, and accumulator
// - halfword long mac: selected signed halves multiplied, sign-extended, added to pair
// - unselected halfwords never reach the halfword multiplier; the word multiplier still takes both full operands
// - dual long mac pairs top-top and bottom-bottom, or crossed when swapped
// - dual long mac adds both products to the 64-bit pair
// - long mac and high-word operations leave condition flags unchanged
// - dual sub: lower product minus upper product plus addend into destination
// - long dual sub: same difference plus 64-bit pair, written back
// - swap option exchanges halves of second operand before both dual subs
// - dual sub sets sticky saturation on accumulate overflow only
// - high-word mac: product, optional round, upper word plus addend
// - high-word subtract: addend minus upper product word
// - rounding adds 0x80000000 to the product before taking high word
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module smd_mac_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic                       CLK_I,
    input  wire logic                       RESET_N_I,
    input  wire logic                       PSEL_I,
    input  wire logic                       PENABLE_I,
    input  wire logic                       PWRITE_I,
    input  wire logic [ADDR_W-1:0]          PADDR_I,
    input  wire logic [smd_pkg::DATA_W-1:0] PWDATA_I,
    output logic      [smd_pkg::DATA_W-1:0] PRDATA_O,
    output logic                            PREADY_O,
    output logic                            PSLVERR_O,
    output logic                            IRQ_O
);
    import smd_pkg::*;

    // the map reaches 0x2c, and the decode is 12 bits wide
    if (ADDR_W < 6 || ADDR_W > 12) begin : g_bad_addr_w
        $error("smd_mac_top: ADDR_W must be 6..12");
    end

    // register state
    logic [DATA_W-1:0]      first_operand_reg, first_operand_next;
    logic [DATA_W-1:0]      second_operand_reg, second_operand_next;
    logic [DATA_W-1:0]      addend_source_reg, addend_source_next;
    logic [DATA_W-1:0]      low_dest_word_reg, low_dest_word_next;
    logic [DATA_W-1:0]      high_dest_word_reg, high_dest_word_next;
    logic [DATA_W-1:0]      dest_reg, dest_next;
    logic [CTRL_KEEP_W-1:0] ctrl_reg, ctrl_next;
    logic                   sat_reg, sat_next;
    logic [FLAGS_W-1:0]     cond_flags_reg, cond_flags_next;
    logic [IRQ_W-1:0]       irq_stat_reg, irq_stat_next;
    logic [IRQ_W-1:0]       irq_en_reg, irq_en_next;
    logic [DATA_W-1:0]      prdata_reg, prdata_next;
    logic                   slverr_reg, slverr_next;
    smd_state_t             state_reg, state_next;

    // bus decode
    logic              setup;
    logic              wr_acc;
    logic [11:0]       addr;
    logic              hit;
    logic              busy;

    assign setup  = PSEL_I && !PENABLE_I;
    assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
    assign addr   = 12'(PADDR_I);
    assign busy   = (state_reg != ST_IDLE);

    function automatic logic mapped(input logic [11:0] a);
        return a == OFS_FIRST_OP || a == OFS_SECOND_OP || a == OFS_ADDEND
            || a == OFS_LOW_DEST || a == OFS_HIGH_DEST || a == OFS_DEST
            || a == OFS_CTRL || a == OFS_STATUS || a == OFS_COND_FLAGS
            || a == OFS_IRQ_STAT || a == OFS_IRQ_EN || a == OFS_IRQ_CLR;
    endfunction : mapped

    function automatic logic wr_to(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction : wr_to

    assign hit = mapped(addr);

    // operation fields
    smd_op_t op;
    logic    swap, round, first_top, second_top;

    assign op         = smd_op_t'(ctrl_reg[CTRL_OP_LSB +: CTRL_OP_W]);
    assign swap       = ctrl_reg[CTRL_SWAP];
    assign round      = ctrl_reg[CTRL_ROUND];
    assign first_top  = ctrl_reg[CTRL_FIRST_TOP];
    assign second_top = ctrl_reg[CTRL_SECOND_TOP];

    // multiplier inputs: lane 0 is the lower pairing, lane 1 the upper
    logic [HALF_W-1:0]   a_lo, a_hi, b_lo, b_hi;
    logic [2*HALF_W-1:0] half_a, half_b;
    logic [LONG_W-1:0]   word_prod;
    logic [LONG_W-1:0]   half_prods;
    logic                mul_en;

    assign a_lo = first_operand_reg[HALF_W-1:0];
    assign a_hi = first_operand_reg[DATA_W-1:HALF_W];
    assign b_lo = second_operand_reg[HALF_W-1:0];
    assign b_hi = second_operand_reg[DATA_W-1:HALF_W];

    always_comb begin
        if (op == OP_HALF_LONG_MAC) begin
            // only the chosen halves enter, the others are zeroed out
            half_a = {{HALF_W{1'b0}}, first_top ? a_hi : a_lo};
            half_b = {{HALF_W{1'b0}}, second_top ? b_hi : b_lo};
        end else begin
            half_a = {a_hi, a_lo};
            half_b = swap ? {b_lo, b_hi} : {b_hi, b_lo};
        end
    end

    assign mul_en = (state_reg == ST_MUL);

    smd_word_mul u_word_mul (
        .CLK_I     (CLK_I),
        .RESET_N_I (RESET_N_I),
        .en_i      (mul_en),
        .a_i       (first_operand_reg),
        .b_i       (second_operand_reg),
        .prod_o    (word_prod)
    );

    smd_half_mul u_half_mul (
        .CLK_I     (CLK_I),
        .RESET_N_I (RESET_N_I),
        .en_i      (mul_en),
        .a_i       (half_a),
        .b_i       (half_b),
        .prod_o    (half_prods)
    );

    // accumulate stage arithmetic
    logic [DATA_W-1:0] p_lo, p_hi;
    logic [LONG_W-1:0] pair, p_lo_x, p_hi_x, diff_x, rounded;
    logic [DATA_W:0]   short_sum;
    logic [DATA_W-1:0] high_word;
    logic [LONG_W-1:0] long_res;
    logic [DATA_W-1:0] short_res;
    logic              long_wr, short_wr, ovf;

    assign p_lo    = half_prods[DATA_W-1:0];
    assign p_hi    = half_prods[LONG_W-1:DATA_W];
    assign pair    = {high_dest_word_reg, low_dest_word_reg};
    assign p_lo_x  = {{DATA_W{p_lo[DATA_W-1]}}, p_lo};
    assign p_hi_x  = {{DATA_W{p_hi[DATA_W-1]}}, p_hi};
    // difference of two 16x16 products always fits, so only the add can overflow
    assign diff_x  = p_lo_x - p_hi_x;
    assign rounded = round ? word_prod + ROUND_CONST : word_prod;
    assign high_word = rounded[LONG_W-1:DATA_W];
    assign short_sum = {diff_x[DATA_W-1], diff_x[DATA_W-1:0]}
                     + {addend_source_reg[DATA_W-1], addend_source_reg};

    always_comb begin
        long_res  = pair;
        short_res = dest_reg;
        long_wr   = 1'b0;
        short_wr  = 1'b0;
        ovf       = 1'b0;
        unique case (op)
            OP_WORD_LONG_MAC: begin
                long_res = pair + word_prod;
                long_wr  = 1'b1;
            end
            OP_HALF_LONG_MAC: begin
                long_res = pair + p_lo_x;
                long_wr  = 1'b1;
            end
            OP_DUAL_HALF_LONG_MAC: begin
                long_res = pair + p_lo_x + p_hi_x;
                long_wr  = 1'b1;
            end
            OP_DUAL_HALF_MUL_SUB_ACC: begin
                short_res = short_sum[DATA_W-1:0];
                short_wr  = 1'b1;
                ovf       = short_sum[DATA_W] != short_sum[DATA_W-1];
            end
            OP_DUAL_HALF_MUL_SUB_LONG: begin
                long_res = pair + diff_x;
                long_wr  = 1'b1;
            end
            OP_HIGH_WORD_MUL_ADD: begin
                short_res = addend_source_reg + high_word;
                short_wr  = 1'b1;
            end
            OP_HIGH_WORD_MUL_SUBTRACT: begin
                short_res = addend_source_reg - high_word;
                short_wr  = 1'b1;
            end
            default: begin
                // unused op code completes with no result
                long_wr = 1'b0;
            end
        endcase
    end

    // next state of all registers
    always_comb begin
        first_operand_next  = first_operand_reg;
        second_operand_next = second_operand_reg;
        addend_source_next  = addend_source_reg;
        low_dest_word_next  = low_dest_word_reg;
        high_dest_word_next = high_dest_word_reg;
        dest_next           = dest_reg;
        ctrl_next           = ctrl_reg;
        sat_next            = sat_reg;
        cond_flags_next     = cond_flags_reg;
        irq_stat_next       = irq_stat_reg;
        irq_en_next         = irq_en_reg;
        state_next          = state_reg;
        prdata_next         = prdata_reg;
        slverr_next         = slverr_reg;

        // software writes; operands and pair are locked while an operation runs
        if (wr_acc) begin
            if (!busy && wr_to(addr, OFS_FIRST_OP))   first_operand_next  = PWDATA_I;
            if (!busy && wr_to(addr, OFS_SECOND_OP))  second_operand_next = PWDATA_I;
            if (!busy && wr_to(addr, OFS_ADDEND))     addend_source_next  = PWDATA_I;
            if (!busy && wr_to(addr, OFS_LOW_DEST))   low_dest_word_next  = PWDATA_I;
            if (!busy && wr_to(addr, OFS_HIGH_DEST))  high_dest_word_next = PWDATA_I;
            if (!busy && wr_to(addr, OFS_DEST))       dest_next           = PWDATA_I;
            if (wr_to(addr, OFS_COND_FLAGS))          cond_flags_next = PWDATA_I[FLAGS_W-1:0];
            if (wr_to(addr, OFS_IRQ_EN))              irq_en_next     = PWDATA_I[IRQ_W-1:0];
            if (wr_to(addr, OFS_IRQ_CLR))
                irq_stat_next = irq_stat_reg & ~PWDATA_I[IRQ_W-1:0];
            if (wr_to(addr, OFS_STATUS) && PWDATA_I[ST_SAT])
                sat_next = 1'b0;
            if (!busy && wr_to(addr, OFS_CTRL)) begin
                ctrl_next = PWDATA_I[CTRL_KEEP_W-1:0];
                if (PWDATA_I[CTRL_START]) state_next = ST_MUL;
            end
        end

        if (state_reg == ST_MUL) begin
            state_next = ST_ACC;
        end
        // hardware sets come last so they win over a same-cycle clear
        if (state_reg == ST_ACC) begin
            state_next = ST_IDLE;
            if (long_wr) begin
                low_dest_word_next  = long_res[DATA_W-1:0];
                high_dest_word_next = long_res[LONG_W-1:DATA_W];
            end
            if (short_wr) dest_next = short_res;
            // condition flags are software-owned and never touched here
            cond_flags_next = cond_flags_next;
            if (ovf) begin
                sat_next               = 1'b1;
                irq_stat_next[IRQ_SAT] = 1'b1;
            end
            irq_stat_next[IRQ_DONE] = 1'b1;
        end

        // read data captured in the setup phase, presented in the access phase
        if (setup) begin
            slverr_next = !hit;
            prdata_next = RST_WORD;
            unique case (addr)
                OFS_FIRST_OP:   prdata_next = first_operand_reg;
                OFS_SECOND_OP:  prdata_next = second_operand_reg;
                OFS_ADDEND:     prdata_next = addend_source_reg;
                OFS_LOW_DEST:   prdata_next = low_dest_word_reg;
                OFS_HIGH_DEST:  prdata_next = high_dest_word_reg;
                OFS_DEST:       prdata_next = dest_reg;
                OFS_CTRL:       prdata_next[CTRL_KEEP_W-1:0] = ctrl_reg;
                OFS_STATUS: begin
                    prdata_next[ST_BUSY] = busy;
                    prdata_next[ST_SAT]  = sat_reg;
                end
                OFS_COND_FLAGS: prdata_next[FLAGS_W-1:0] = cond_flags_reg;
                OFS_IRQ_STAT:   prdata_next[IRQ_W-1:0]   = irq_stat_reg;
                OFS_IRQ_EN:     prdata_next[IRQ_W-1:0]   = irq_en_reg;
                default:        prdata_next = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            first_operand_reg  <= RST_WORD;
            second_operand_reg <= RST_WORD;
            addend_source_reg  <= RST_WORD;
            low_dest_word_reg  <= RST_WORD;
            high_dest_word_reg <= RST_WORD;
            dest_reg           <= RST_WORD;
            ctrl_reg           <= '0;
            sat_reg            <= 1'b0;
            cond_flags_reg     <= '0;
            irq_stat_reg       <= '0;
            irq_en_reg         <= '0;
            state_reg          <= ST_IDLE;
            prdata_reg         <= RST_WORD;
            slverr_reg         <= 1'b0;
        end else begin
            first_operand_reg  <= first_operand_next;
            second_operand_reg <= second_operand_next;
            addend_source_reg  <= addend_source_next;
            low_dest_word_reg  <= low_dest_word_next;
            high_dest_word_reg <= high_dest_word_next;
            dest_reg           <= dest_next;
            ctrl_reg           <= ctrl_next;
            sat_reg            <= sat_next;
            cond_flags_reg     <= cond_flags_next;
            irq_stat_reg       <= irq_stat_next;
            irq_en_reg         <= irq_en_next;
            state_reg          <= state_next;
            prdata_reg         <= prdata_next;
            slverr_reg         <= slverr_next;
        end
    end

    // zero-wait slave: every access phase completes at once
    assign PREADY_O  = 1'b1;
    assign PRDATA_O  = prdata_reg;
    assign PSLVERR_O = PSEL_I && PENABLE_I && slverr_reg;
    assign IRQ_O     = |(irq_stat_reg & irq_en_reg);
endmodule : smd_mac_top

// file: smd_mac_props.sv
// concurrent checks on the apb and interrupt ports of the unit
`timescale 1ns/1ps
module smd_mac_props #(
    parameter int ADDR_W = 12
) (
    input wire logic                       CLK_I,
    input wire logic                       RESET_N_I,
    input wire logic                       PSEL_I,
    input wire logic                       PENABLE_I,
    input wire logic                       PWRITE_I,
    input wire logic [ADDR_W-1:0]          PADDR_I,
    input wire logic [smd_pkg::DATA_W-1:0] PWDATA_I,
    input wire logic [smd_pkg::DATA_W-1:0] PRDATA_O,
    input wire logic                       PREADY_O,
    input wire logic                       PSLVERR_O,
    input wire logic                       IRQ_O
);
    import smd_pkg::*;
    logic [1:0] en_reg;
    logic [1:0] en_next;
    logic       acc_wr;
    assign acc_wr = PSEL_I && PENABLE_I && PWRITE_I;
    // shadow of the enable register, so masking can be judged at the pins
    always_comb begin
        en_next = en_reg;
        if (acc_wr && PADDR_I == OFS_IRQ_EN) begin
            en_next = PWDATA_I[1:0];
        end
    end
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            en_reg <= 2'h0;
        end else begin
            en_reg <= en_next;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    a_ready_high: assert property (PREADY_O) else $error("ready low");
    a_err_access: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
        else $error("error outside access");
    a_err_unmapped: assert property (PSEL_I && PENABLE_I && PADDR_I > OFS_IRQ_CLR |-> PSLVERR_O)
        else $error("no error on unmapped");
    a_ok_mapped: assert property (PSEL_I && PENABLE_I && PADDR_I <= OFS_IRQ_CLR
        && PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O) else $error("error on mapped");
    a_rdata_hold: assert property (!(PSEL_I && !PENABLE_I) |=> $stable(PRDATA_O))
        else $error("read data moved");
    a_rdata_unmapped: assert property (PSEL_I && !PENABLE_I && !PWRITE_I
        && PADDR_I > OFS_IRQ_CLR |=> PRDATA_O == 32'h0) else $error("unmapped data");
    a_irq_masked: assert property (en_reg == 2'h0 |-> !IRQ_O) else $error("masked irq");
    a_done_irq: assert property (acc_wr && PADDR_I == OFS_CTRL && PWDATA_I[CTRL_START]
        && en_reg[IRQ_DONE] |-> ##[3:4] IRQ_O) else $error("no done irq");
    a_clear_drops: assert property (acc_wr && PADDR_I == OFS_IRQ_CLR
        && PWDATA_I[1:0] == 2'h3 |=> !IRQ_O) else $error("irq after clear");
endmodule : smd_mac_props
bind smd_mac_top smd_mac_props #(.ADDR_W(ADDR_W)) u_smd_mac_props (.CLK_I(CLK_I),
    .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O));

// file: smd_apb_host.sv
// apb master standing in for the core's decode and register file
`timescale 1ns/1ps
module smd_apb_host (
    input  wire logic        clk_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    input  wire logic [31:0] prdata_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [11:0] paddr_o,
    output logic      [31:0] pwdata_o
);
    logic hung = 1'b0;
    logic err;
    initial begin
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
    end
    // fixed pair, plain data registers: no stack pointer or program counter
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge clk_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= w;
        paddr_o   <= a;
        pwdata_o  <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 16);
        if (n >= 16) hung = 1'b1;
        q   = prdata_i;
        err = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        // released data must not look like the last value
        pwdata_o  <= ~d;
    endtask : xfer
endmodule : smd_apb_host

// file: smd_mac_top_bench.sv
// self-checking bench of the multiply-accumulate unit
`timescale 1ns/1ps
module smd_mac_top_bench;
    import smd_pkg::*;
    localparam logic [7:0] CTLS [15] = '{8'h00, 8'h01, 8'h21, 8'h41, 8'h61, 8'h02, 8'h0a,
        8'h03, 8'h0b, 8'h04, 8'h0c, 8'h05, 8'h15, 8'h06, 8'h16};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          mismatches = 0;
    int          cmp_count = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    smd_mac_top #(.ADDR_W(12)) u_smd_mac_top (.CLK_I(clk), .RESET_N_I(rst_n),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .IRQ_O(irq));
    smd_apb_host u_smd_apb_host (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr),
        .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata));
    task automatic finish_test;
        if (u_smd_apb_host.hung) mismatches++;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_smd_apb_host.xfer(1'b1, a, d, q);
        if (u_smd_apb_host.hung) finish_test();
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [63:0] e, input string nm);
        u_smd_apb_host.xfer(1'b0, a, 32'h0, q);
        if (u_smd_apb_host.hung) finish_test();
        chk(nm, e, {32'h0, q});
    endtask : rd
    task automatic run(input logic [7:0] k);
        int n;
        wr(OFS_CTRL, {23'h0, 1'b1, k});
        n = 0;
        // poll busy with a bound, the latency is not assumed
        do begin
            u_smd_apb_host.xfer(1'b0, OFS_STATUS, 32'h0, q);
            n++;
        end while (q[ST_BUSY] !== 1'b0 && n < 8);
        if (n >= 8) mismatches++;
        if (n >= 8) finish_test();
    endtask : run
    function automatic logic [96:0] ref_op(input logic [7:0] k, input logic [31:0] a, b,
                                           c, input logic [63:0] p);
        logic signed [63:0] l0, l1, pr, d, h;
        logic signed [15:0] ha, hb;
        logic        [31:0] bs, dst;
        bs  = k[3] ? {b[15:0], b[31:16]} : b;
        l0  = $signed(a[15:0]) * $signed(bs[15:0]);
        l1  = $signed(a[31:16]) * $signed(bs[31:16]);
        ha  = k[5] ? a[31:16] : a[15:0];
        hb  = k[6] ? b[31:16] : b[15:0];
        h   = ha * hb;
        pr  = $signed(a) * $signed(b);
        if (k[4]) pr = pr + 64'sh8000_0000;
        d   = l0 - l1 + $signed(c);
        dst = 32'h5a5a_5a5a;
        case (k[2:0])
            3'h0: p = p + pr;
            3'h1: p = p + h;
            3'h2: p = p + l0 + l1;
            3'h3: dst = d[31:0];
            3'h4: p = p + l0 - l1;
            3'h5: dst = c + pr[63:32];
            3'h6: dst = c - pr[63:32];
            default: ;
        endcase
        return {p, dst, k[2:0] == 3'h3 && d[63:31] != {33{d[31]}}};
    endfunction : ref_op
    initial begin
        logic [96:0] r;
        logic [31:0] a, b;
        logic [63:0] p;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL, 0, "ctrl_rst");
        rd(OFS_STATUS, 0, "status_rst");
        rd(OFS_IRQ_STAT, 0, "irq_stat_rst");
        wr(OFS_COND_FLAGS, 32'ha);
        wr(OFS_IRQ_EN, 32'h3);
        for (int i = 0; i < 30; i++) begin
            a = i[0] ? 32'h7fff_8000 : 32'h8000_0003;
            b = i[0] ? 32'h7fff_8000 : 32'h7fff_fffd;
            p = i[0] ? 64'h4000_0000_0000_0000 : 64'hffff_ffff_ffff_fff0;
            r = ref_op(CTLS[i/2], a, b, 32'h7fff_ffff, p);
            wr(OFS_FIRST_OP, a);
            wr(OFS_SECOND_OP, b);
            wr(OFS_ADDEND, 32'h7fff_ffff);
            wr(OFS_LOW_DEST, p[31:0]);
            wr(OFS_HIGH_DEST, p[63:32]);
            wr(OFS_DEST, 32'h5a5a_5a5a);
            run(CTLS[i/2]);
            rd(OFS_LOW_DEST, r[64:33], "low");
            rd(OFS_HIGH_DEST, r[96:65], "high");
            rd(OFS_DEST, r[32:1], "dest");
            rd(OFS_STATUS, {r[0], 1'b0}, "sat");
            rd(OFS_IRQ_STAT, {r[0], 1'b1}, "irq_stat");
            chk("irq_set", 1, irq);
            wr(OFS_IRQ_CLR, 32'h3);
            wr(OFS_STATUS, 32'h2);
            @(negedge clk);
            chk("irq_clr", 0, irq);
        end
        rd(OFS_CTRL, 32'h16, "ctrl_keep");
        rd(12'h030, 0, "unmapped");
        chk("unmapped_err", 1, u_smd_apb_host.err);
        // masked event still latches, line stays low until enabled
        wr(OFS_IRQ_EN, 32'h0);
        run(8'h00);
        @(negedge clk);
        chk("irq_masked", 0, irq);
        rd(OFS_IRQ_STAT, 1, "done_masked");
        wr(OFS_IRQ_EN, 32'h1);
        @(negedge clk);
        chk("irq_unmask", 1, irq);
        wr(OFS_IRQ_CLR, 32'h1);
        @(negedge clk);
        chk("irq_clr1", 0, irq);
        // unused op code only signals done, destination keeps the last result
        run(8'h07);
        rd(OFS_DEST, r[32:1], "noop_dest");
        rd(OFS_COND_FLAGS, 32'ha, "flags");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_COND_FLAGS, 0, "flags_rst");
        rd(OFS_HIGH_DEST, 0, "high_rst");
        chk("irq_rst", 0, irq);
        finish_test();
    end
endmodule : smd_mac_top_bench
